// >>> core/sdsi_pkg.sv
// Shared constants for the serial diagnosis switch interface
package sdsi_pkg;
	// ****************************************
	// Frame layout
	// ****************************************
	localparam int FRAME_BITS = 16;
	localparam int CHANNELS = 16;
	localparam int DIAG_BITS = 2;
	localparam int CNT_W = 5;
	localparam logic [4:0] FRAME_LAST = 5'h0F;
	localparam logic [15:0] SHIFT_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	// Diagnosis codes, two bits per channel
	localparam logic [1:0] DIAG_OK = 2'h3;
	localparam logic [1:0] DIAG_PROT = 2'h2;
	localparam logic [1:0] DIAG_OPEN = 2'h1;
	localparam logic [1:0] DIAG_SHG = 2'h0;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int FAULT_DLY_MIN_US = 50;
	localparam int FAULT_DLY_MAX_US = 200;
	localparam int CS_GAP_NS = 200;
	localparam int LEAD_NS = 200;
	localparam int LAG_NS = 200;
	localparam int SCK_HALF_NS = 100;
	localparam int FAULT_DLY_CYC = (FAULT_DLY_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LEAD_CYC = (LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LAG_CYC = (LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIAG_GAP_CYC = (FAULT_DLY_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 18;
endpackage

// >>> core/sdsi_if.sv
// Link signals between the host master and the switch device
`timescale 1ns/1ps
`default_nettype none
interface sdsi_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so_o;
	logic so_oe;
	logic fault_n_o;
	logic fault_n_oe;
	// Resolved pin levels: fault line pulled up, idle serial output reads high
	wire so = so_oe ? so_o : 1'b1;
	wire fault_n = (fault_n_oe && !fault_n_o) ? 1'b0 : 1'b1;

	modport dev (
		input cs_n,
		input sclk,
		input si,
		input so,
		output so_o,
		output so_oe,
		output fault_n_o,
		output fault_n_oe
	);
	modport host (
		output cs_n,
		output sclk,
		output si,
		input so,
		input fault_n
	);
endinterface
`default_nettype wire

// >>> core/sdsi_dev.sv
// Device end: serial shift register, diagnosis latch and fault pin
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Fault pin low on any channel error
// - Fault latched into diagnosis register until read (code clears both halves at each select fall; a frame reads one half)
// - Newer error overwrites stored report
// - Per channel: protective, open load, short
// - Fault reported after delay; host waits 200us
// - Host keeps select high 200ns between frames
// - Serial output tri-stated while select high
// - Select fall loads diagnosis into shifter
// - Select low drives current shifter bit
// - Input bits accepted only while select low
// - Select rise copies bits to control buffers
// - Host holds clock low at select fall
// - Clock and input ignored while select high
// - Input sampled on clock falling edge
// - Host keeps 200ns lead and lag
// - Output shifts on clock rising edge
// - Sixteen-bit frames, MSB first, control then data
// - Reset clears shifter and outputs off
module sdsi_dev (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Link
	sdsi_if.dev lnk,
	// Analog fault detectors per channel
	input wire logic [15:0] i_prot,
	input wire logic [15:0] i_open,
	input wire logic [15:0] i_short,
	// Received frame
	output logic [15:0] o_ctrl,
	output logic o_ctrl_valid
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic cs_s1_q, cs_s2_q, cs_s3_q;
	logic ck_s1_q, ck_s2_q, ck_s3_q;
	logic si_s1_q, si_s2_q;
	always_ff @(posedge i_clk)
	begin
		cs_s1_q <= lnk.cs_n;
		cs_s2_q <= cs_s1_q;
		cs_s3_q <= cs_s2_q;
		ck_s1_q <= lnk.sclk;
		ck_s2_q <= ck_s1_q;
		ck_s3_q <= ck_s2_q;
		si_s1_q <= lnk.si;
		si_s2_q <= si_s1_q;
	end
	wire cs_fall = cs_s3_q && !cs_s2_q;
	wire cs_rise = !cs_s3_q && cs_s2_q;
	wire cs_low = !cs_s2_q;
	wire ck_rise = !ck_s3_q && ck_s2_q && cs_low;
	wire ck_fall = ck_s3_q && !ck_s2_q && cs_low;

	// ****************************************
	// Fault qualification and diagnosis latch
	// ****************************************
	// Detector levels arrive from another domain: two flops before any use
	// Each bit is an independent level, so no word handshake is needed
	logic [15:0] prot_s1_q, prot_s2_q;
	logic [15:0] open_s1_q, open_s2_q;
	logic [15:0] short_s1_q, short_s2_q;
	always_ff @(posedge i_clk)
	begin
		prot_s1_q <= i_prot;
		prot_s2_q <= prot_s1_q;
		open_s1_q <= i_open;
		open_s2_q <= open_s1_q;
		short_s1_q <= i_short;
		short_s2_q <= short_s1_q;
	end
	logic [15:0] raw_err;
	assign raw_err = prot_s2_q | open_s2_q | short_s2_q;
	logic [15:0] err_q;
	logic [sdsi_pkg::TMR_W-1:0] dly_q [sdsi_pkg::CHANNELS];
	logic [1:0] diag_q [sdsi_pkg::CHANNELS];
	logic [15:0] pend_q;
	localparam logic [sdsi_pkg::TMR_W-1:0] DLY_END = sdsi_pkg::TMR_W'(sdsi_pkg::FAULT_DLY_CYC);

	genvar g;
	generate
		for (g = 0; g < sdsi_pkg::CHANNELS; g++)
		begin : g_ch
			// Priority: protective event outranks open load and short
			wire [1:0] code = prot_s2_q[g] ? sdsi_pkg::DIAG_PROT :
				open_s2_q[g] ? sdsi_pkg::DIAG_OPEN :
				short_s2_q[g] ? sdsi_pkg::DIAG_SHG : sdsi_pkg::DIAG_OK;
			wire done = dly_q[g] == DLY_END;
			always_ff @(posedge i_clk)
			begin
				if (i_rst || !raw_err[g])
					dly_q[g] <= '0;
				else if (!done)
					dly_q[g] <= dly_q[g] + 1'b1;
			end
			always_ff @(posedge i_clk)
			begin
				if (i_rst)
					err_q[g] <= 1'b0;
				else
					err_q[g] <= done;
			end
			always_ff @(posedge i_clk)
			begin
				if (i_rst)
					diag_q[g] <= sdsi_pkg::DIAG_OK;
				else if (done)
					diag_q[g] <= code;
				else if (cs_fall)
					diag_q[g] <= sdsi_pkg::DIAG_OK;
			end
			// Set wins over the clear at select fall
			always_ff @(posedge i_clk)
			begin
				if (i_rst)
					pend_q[g] <= 1'b0;
				else if (done)
					pend_q[g] <= 1'b1;
				else if (cs_fall)
					pend_q[g] <= 1'b0;
			end
		end
	endgenerate

	// Only eight channels fit a frame; halves alternate on each select fall, low half first after reset
	logic [15:0] diag_word;
	logic hi_sel_q;
	always_comb
	begin
		diag_word = '0;
		for (int i = 0; i < 8; i++)
			diag_word[2*i +: 2] = hi_sel_q ? diag_q[i+8] : diag_q[i];
	end

	// ****************************************
	// Shift register
	// ****************************************
	logic [15:0] shift_q;
	logic so_q;
	logic [sdsi_pkg::CNT_W-1:0] cnt_q;
	// Only a complete frame reaches the control buffer; a cut frame is dropped
	wire frame_full = cnt_q == sdsi_pkg::CNT_W'(sdsi_pkg::FRAME_BITS);
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			shift_q <= sdsi_pkg::SHIFT_RST;
		else if (cs_fall)
			shift_q <= diag_word;
		else if (ck_fall)
			shift_q <= {shift_q[14:0], si_s2_q};
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			so_q <= 1'b0;
		else if (cs_fall)
			so_q <= diag_word[15];
		else if (ck_rise)
			so_q <= shift_q[15];
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst || cs_fall)
			cnt_q <= '0;
		else if (ck_fall && !frame_full)
			cnt_q <= cnt_q + 1'b1;
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			hi_sel_q <= 1'b0;
		else if (cs_fall)
			hi_sel_q <= ~hi_sel_q;
	end

	// ****************************************
	// Control buffer and pins
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_ctrl <= sdsi_pkg::CTRL_RST;
			o_ctrl_valid <= 1'b0;
		end
		else
		begin
			o_ctrl_valid <= cs_rise && frame_full;
			if (cs_rise && frame_full)
				o_ctrl <= shift_q;
		end
	end
	assign lnk.so_o = so_q;
	// Enable waits for the shifter load so no stale bit reaches the pin
	wire so_en = cs_low && !cs_s3_q;
	assign lnk.so_oe = so_en && !i_rst;
	// Alert pin only pulls low; pending faults clear on the next readout
	assign lnk.fault_n_o = 1'b0;
	assign lnk.fault_n_oe = |(pend_q | err_q);
endmodule // sdsi_dev
`default_nettype wire

// >>> core/sdsi_host.sv
// Host end: serial master issuing sixteen-bit frames
`timescale 1ns/1ps
`default_nettype none
module sdsi_host (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Link
	sdsi_if.host lnk,
	// User request
	input wire logic i_start,
	input wire logic [15:0] i_tx,
	output logic o_ready,
	output logic [15:0] o_rx,
	output logic o_done,
	output logic o_fault
);
	typedef enum {ST_IDLE, ST_LEAD, ST_HI, ST_LO, ST_LAG, ST_GAP} sdsih_st_t;
	sdsih_st_t st_q;
	logic [15:0] tx_q;
	logic [15:0] rx_q;
	logic [4:0] bit_q;
	logic [sdsi_pkg::TMR_W-1:0] tmr_q;
	logic cs_q, ck_q, f1_q, f2_q, so1_q, so2_q;
	localparam logic [sdsi_pkg::TMR_W-1:0] T_LEAD = sdsi_pkg::TMR_W'(sdsi_pkg::LEAD_CYC);
	localparam logic [sdsi_pkg::TMR_W-1:0] T_HALF = sdsi_pkg::TMR_W'(sdsi_pkg::SCK_HALF_CYC);
	localparam logic [sdsi_pkg::TMR_W-1:0] T_LAG = sdsi_pkg::TMR_W'(sdsi_pkg::LAG_CYC);
	// Gap covers worst-case fault delay, which also satisfies the short gap
	localparam logic [sdsi_pkg::TMR_W-1:0] T_GAP = sdsi_pkg::TMR_W'(sdsi_pkg::DIAG_GAP_CYC);
	wire t_end = tmr_q == '0;

	always_ff @(posedge i_clk)
	begin
		so1_q <= lnk.so;
		so2_q <= so1_q;
		f1_q <= lnk.fault_n;
		f2_q <= f1_q;
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st_q <= ST_IDLE;
			cs_q <= 1'b1;
			ck_q <= 1'b0;
			tmr_q <= '0;
			bit_q <= '0;
			tx_q <= '0;
			rx_q <= '0;
			o_rx <= '0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			if (!t_end)
				tmr_q <= tmr_q - 1'b1;
			case (st_q)
				ST_IDLE:
					if (i_start)
					begin
						tx_q <= i_tx;
						cs_q <= 1'b0;
						tmr_q <= T_LEAD;
						bit_q <= '0;
						st_q <= ST_LEAD;
					end
				ST_LEAD:
					if (t_end)
					begin
						ck_q <= 1'b1;
						tmr_q <= T_HALF;
						st_q <= ST_HI;
					end
				ST_HI:
					if (t_end)
					begin
						ck_q <= 1'b0;
						rx_q <= {rx_q[14:0], so2_q};
						tmr_q <= T_HALF;
						st_q <= ST_LO;
					end
				ST_LO:
					if (t_end)
					begin
						tx_q <= {tx_q[14:0], 1'b0};
						bit_q <= bit_q + 1'b1;
						if (bit_q == sdsi_pkg::FRAME_LAST)
						begin
							tmr_q <= T_LAG;
							st_q <= ST_LAG;
						end
						else
						begin
							ck_q <= 1'b1;
							tmr_q <= T_HALF;
							st_q <= ST_HI;
						end
					end
				ST_LAG:
					if (t_end)
					begin
						cs_q <= 1'b1;
						o_rx <= rx_q;
						o_done <= 1'b1;
						tmr_q <= T_GAP;
						st_q <= ST_GAP;
					end
				ST_GAP:
					if (t_end)
						st_q <= ST_IDLE;
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end
	assign lnk.cs_n = cs_q;
	assign lnk.sclk = ck_q;
	assign lnk.si = tx_q[15];
	assign o_ready = st_q == ST_IDLE;
	assign o_fault = !f2_q;
endmodule // sdsi_host
`default_nettype wire

// >>> test/sdsi_checker.sv
// Link timing and fault pin checks
`timescale 1ns/1ps
`default_nettype none
module sdsi_checker (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic so_o,
	input wire logic so_oe,
	input wire logic fault_n_oe
);
	// ****
	// Helpers
	// ****
	logic [13:0] up_q;
	logic [4:0] nr_q;
	logic sk_q;
	always_ff @(posedge i_clk)
	begin
		sk_q <= sclk;
		up_q <= i_rst ? 14'h0000 : up_q + {13'h0000, ~&up_q};
		nr_q <= (i_rst || cs_n) ? 5'h00 : nr_q + {4'h0, sclk & ~sk_q};
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_so_idle_hiz: assert property (cs_n [*4] |-> !so_oe)
		else $error("so driven while deselected");
	a_so_drive_sel: assert property (!cs_n [*4] |-> so_oe)
		else $error("so not driven while selected");
	a_rst_pins_off: assert property (disable iff (1'b0) i_rst |=> !so_oe && !fault_n_oe)
		else $error("pins active in reset");
	a_so_only_rise: assert property ((!cs_n && $stable(sclk)) [*8] |-> $stable(so_o))
		else $error("so moved without clock rise");
	// Slack of two edges covers the pin register after the latch
	a_fault_not_early: assert property ($rose(fault_n_oe) |-> up_q >= 14'(sdsi_pkg::FAULT_DLY_CYC - 2))
		else $error("fault reported too early");
	a_fault_rel_read: assert property ($fell(fault_n_oe) && !$past(i_rst) |-> !cs_n)
		else $error("fault released without readout");
	a_cs_edge_slow: assert property ($changed(cs_n) |-> !sclk)
		else $error("clock high at select edge");
	a_lead_quiet: assert property ($fell(cs_n) |=> !sclk [*8])
		else $error("clock too soon after select");
	a_frame_bits: assert property ($rose(cs_n) |-> nr_q == 5'h10)
		else $error("frame not sixteen clocks");
endmodule // sdsi_checker
`default_nettype wire

// >>> test/tb.sv
// Bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_start = 1'b0;
	logic [15:0] i_tx = 16'h0000;
	logic [15:0] i_prot = 16'h0000;
	logic [15:0] i_open = 16'h0000;
	logic [15:0] i_short = 16'h0000;
	logic [15:0] o_ctrl;
	logic [15:0] o_rx;
	logic o_ctrl_valid;
	logic o_ready;
	logic o_done;
	logic o_fault;
	int n_errors = 0;
	int samples_checked = 0;
	int seed = 83;
	int b;
	logic [15:0] exp_q[$];
	always #2 i_clk = ~i_clk;
	sdsi_if lnk ();
	sdsi_dev i_sdsi_dev (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk.dev), .i_prot(i_prot),
		.i_open(i_open), .i_short(i_short), .o_ctrl(o_ctrl), .o_ctrl_valid(o_ctrl_valid));
	sdsi_host i_sdsi_host (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk.host), .i_start(i_start),
		.i_tx(i_tx), .o_ready(o_ready), .o_rx(o_rx), .o_done(o_done), .o_fault(o_fault));
	sdsi_checker i_sdsi_checker (.i_clk(i_clk), .i_rst(i_rst), .cs_n(lnk.cs_n),
		.sclk(lnk.sclk), .so_o(lnk.so_o), .so_oe(lnk.so_oe), .fault_n_oe(lnk.fault_n_oe));
	// ****
	// Model and tasks
	// ****
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
		samples_checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Two bits per channel, protective wins over open, open over short
	function automatic logic [15:0] diag(input int h);
		logic [15:0] w;
		int c;
		for (int i = 0; i < 8; i++)
		begin
			c = h * 8 + i;
			w[2*i+:2] = i_prot[c] ? sdsi_pkg::DIAG_PROT : i_open[c] ? sdsi_pkg::DIAG_OPEN
				: i_short[c] ? sdsi_pkg::DIAG_SHG : sdsi_pkg::DIAG_OK;
		end
		return w;
	endfunction
	task automatic frame(input int h);
		logic [15:0] e;
		int k;
		e = diag(h);
		for (k = 0; k < 60000 && o_ready !== 1'b1; k++)
			@(negedge i_clk);
		check("ready", 16'h0001, 16'(o_ready));
		i_tx = 16'($random(seed));
		exp_q.push_back(i_tx);
		i_start = 1'b1;
		@(negedge i_clk);
		i_start = 1'b0;
		for (k = 0; k < 2000 && o_done !== 1'b1; k++)
			@(negedge i_clk);
		check("done", 16'h0001, 16'(o_done));
		check("rx", e, o_rx);
		for (k = 0; k < 20 && o_ctrl_valid !== 1'b1; k++)
			@(negedge i_clk);
		check("valid", 16'h0001, 16'(o_ctrl_valid));
		check("ctrl", exp_q.pop_front(), o_ctrl);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#400000;
		n_errors++;
		$display("watchdog expired");
		results();
	end
	initial
	begin
		repeat (4) @(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		check("fault", 16'h0000, 16'(o_fault));
		b = $unsigned($random(seed)) % 8;
		i_prot[b] = 1'b1;
		i_open[(b + 1) % 8] = 1'b1;
		i_short[(b + 2) % 8] = 1'b1;
		i_open[(b + 3) % 8] = 1'b1;
		i_short[(b + 3) % 8] = 1'b1;
		repeat (6000) @(negedge i_clk);
		check("fault", 16'h0000, 16'(o_fault));
		repeat (7000) @(negedge i_clk);
		check("fault", 16'h0001, 16'(o_fault));
		$display("test fault_delay done");
		// A newer error on a latched channel replaces the stored code
		i_prot[b] = 1'b0;
		i_short[b] = 1'b1;
		repeat (4) @(negedge i_clk);
		frame(0);
		check("fault", 16'h0001, 16'(o_fault));
		$display("test low_half done");
		// Faults go away; the pin must wait for the next readout
		i_prot = 16'h0000;
		i_open = 16'h0000;
		i_short = 16'h0000;
		frame(1);
		repeat (10) @(negedge i_clk);
		check("fault", 16'h0000, 16'(o_fault));
		$display("test high_half done");
		results();
	end
endmodule // tb
`default_nettype wire
